/* File: rtl/pcrs_defs.svh */
`ifndef PCRS_DEFS_SVH
`define PCRS_DEFS_SVH

`define PCRS_PC_W        21
`define PCRS_RST_VEC     21'h000000
`define PCRS_HI_VEC      21'h000008
`define PCRS_LO_VEC      21'h000018
`define PCRS_STEP        21'h000002
`define PCRS_DEPTH       31
`define PCRS_PTR_EMPTY   5'h00
`define PCRS_PTR_ALMOST  5'h1e
`define PCRS_PTR_TOP     5'h1f
`define PCRS_FULL_BIT    7
`define PCRS_UNF_BIT     6
`define PCRS_MEM_128K    32'h00020000
`define PCRS_MEM_64K     32'h00010000
`define PCRS_CFG_SPAN    32'h00000008
`define PCRS_CFG_USED    2'h3
`define PCRS_CFG_OVF_BIT 0
`define PCRS_CFG_RST     48'h000000000001

`endif

/* File: rtl/pcrs_pkg.sv */
package pcrs_pkg;

  typedef enum logic {
    ST_LOAD,
    ST_RUN
  } pcrs_mode_t;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_INT,
    OP_RET,
    OP_POP,
    OP_CALL,
    OP_PUSH,
    OP_JUMP,
    OP_LOWWR,
    OP_INC
  } pcrs_op_t;

  typedef struct packed {
    pcrs_mode_t  st;
    logic [1:0]  cnt;
    logic        run;
    logic [20:0] pc;
    logic [7:0]  hlat;
    logic [4:0]  ulat;
    logic [4:0]  ptr;
    logic        full;
    logic        unf;
    logic [47:0] cfg;
    logic [20:0] fetch;
    logic        fetch_ok;
    logic [15:0] instr;
    logic [20:0] tos;
    logic        devrst;
  } pcrs_regs_t;

endpackage

/* File: rtl/pcrs_stack_mem.sv */
`timescale 1ns/1ps
`include "pcrs_defs.svh"

module pcrs_stack_mem #(
  parameter int DEPTH = `PCRS_DEPTH,
  parameter int W     = `PCRS_PC_W
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         we,
  input  wire logic [4:0]   wr_idx,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [2:0]   be,
  input  wire logic [4:0]   rd_idx,
  output logic      [W-1:0] rd_data
);

  typedef struct packed {
    logic [DEPTH:1][W-1:0] ent;
  } pcrs_mem_t;

  pcrs_mem_t        q;
  pcrs_mem_t        d;
  logic [W-1:0]     mask;

  // byte lanes: low, high, upper
  always_comb begin
    mask = {{(W-16){be[2]}}, {8{be[1]}}, {8{be[0]}}};
    d = q;
    for (int i = 1; i <= DEPTH; i++) begin
      if (we && 32'(wr_idx) == i) begin
        d.ent[i] = (q.ent[i] & ~mask) | (wr_data & mask); // [R14]
      end
    end
  end

  // index zero has no entry behind it
  assign rd_data = (rd_idx == 5'h00 || 32'(rd_idx) > DEPTH) ? '0 : q.ent[rd_idx]; // [R17]

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

/* File: rtl/pcrs_top.sv */
`timescale 1ns/1ps
`include "pcrs_defs.svh"

// Contract
// R1: 21-bit counter; fetch above memory reads zero
// R2: every reset loads counter with 0000h
// R3: interrupt vectors 0008h high, 0018h low
// R4: top four words copied to config on reset; the code copies only the first three
// R5: config bytes ascending; word four reserved
// R6: config at top eight bytes of memory
// R7: low byte direct; upper bytes via latches
// R8: low byte write loads both latches too
// R9: low byte read copies upper bytes to latches
// R10: bit zero held low; step by two
// R11: call, goto, branch load without latches
// R12: push on call/interrupt, pop on returns
// R13: call and return leave latches unchanged
// R14: 31 by 21-bit storage, 5-bit pointer
// R15: push increments pointer, then writes entry
// R16: pop reads entry, then decrements pointer
// R17: reset clears pointer; zero has no entry
// R18: pointer and top entry readable and writable
// R19: software masks interrupts around stack access
// R20: full flag set on 31st push
// R21: overflow option resets; else pointer holds 31
// R22: pop at empty returns zero, sets underflow
// R23: flags in bits 7 and 6; software clears
module pcrs_top #(
  parameter int unsigned MEM_BYTES = `PCRS_MEM_128K
) (
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  input  wire logic        SOFT_RST,
  input  wire logic        STEP_REQ,
  input  wire logic        JUMP_REQ,
  input  wire logic        CALL_REQ,
  input  wire logic [20:0] JUMP_ADDR,
  input  wire logic        INT_HIGH,
  input  wire logic        INT_LOW,
  input  wire logic        RET_REQ,
  input  wire logic        PUSH_REQ,
  input  wire logic        POP_REQ,
  input  wire logic [7:0]  WR_DATA,
  input  wire logic        LOW_WR,
  input  wire logic        LOW_RD,
  input  wire logic        HIGH_LATCH_WR,
  input  wire logic        UPPER_LATCH_WR,
  input  wire logic        PTR_WR,
  input  wire logic        TOP_LOW_WR,
  input  wire logic        TOP_HIGH_WR,
  input  wire logic        TOP_UPPER_WR,
  input  wire logic [15:0] PMEM_DATA,
  output logic      [20:0] PROG_ADDR,
  output logic      [15:0] INSTR,
  output logic      [7:0]  COUNTER_LOW_BYTE,
  output logic      [7:0]  COUNTER_HIGH_LATCH,
  output logic      [4:0]  COUNTER_UPPER_LATCH,
  output logic      [7:0]  RETURN_POINTER,
  output logic      [20:0] TOP_ENTRY,
  output logic      [47:0] CONFIG_WORDS,
  output logic             RUNNING,
  output logic             DEV_RESET
);

  localparam logic [20:0] CFG_BASE = 21'(MEM_BYTES - `PCRS_CFG_SPAN);

  localparam pcrs_pkg::pcrs_regs_t RST_Q = '{
    st:     pcrs_pkg::ST_LOAD,
    cnt:    2'h0,
    run:    1'b0,
    pc:     `PCRS_RST_VEC,
    hlat:   8'h00,
    ulat:   5'h00,
    ptr:    `PCRS_PTR_EMPTY,
    full:   1'b0,
    unf:    1'b0,
    cfg:    `PCRS_CFG_RST,
    fetch:  CFG_BASE,
    fetch_ok: 1'b1,
    instr:  16'h0000,
    tos:    21'h000000,
    devrst: 1'b0
  };

  pcrs_pkg::pcrs_regs_t q;
  pcrs_pkg::pcrs_regs_t d;
  pcrs_pkg::pcrs_op_t   op;
  logic                 wr_en;
  logic [4:0]           wr_idx;
  logic [20:0]          wr_data;
  logic [2:0]           wr_be;
  logic [20:0]          top_rd;
  logic                 stk_rst;
  logic                 push_req;
  logic                 reg_ok;
  logic                 ovf_opt;
  logic                 in_range;

  function automatic pcrs_pkg::pcrs_op_t pick_op(
    input logic ih,
    input logic il,
    input logic rt,
    input logic pp,
    input logic cl,
    input logic ps,
    input logic jp,
    input logic lw,
    input logic st
  );
    pcrs_pkg::pcrs_op_t r;
    r = pcrs_pkg::OP_NONE;
    if (ih || il) begin
      r = pcrs_pkg::OP_INT;
    end else if (rt) begin
      r = pcrs_pkg::OP_RET;
    end else if (pp) begin
      r = pcrs_pkg::OP_POP;
    end else if (cl) begin
      r = pcrs_pkg::OP_CALL;
    end else if (ps) begin
      r = pcrs_pkg::OP_PUSH;
    end else if (jp) begin
      r = pcrs_pkg::OP_JUMP;
    end else if (lw) begin
      r = pcrs_pkg::OP_LOWWR;
    end else if (st) begin
      r = pcrs_pkg::OP_INC;
    end
    return r;
  endfunction

  // one flow event per cycle, interrupt first
  assign op = pick_op(INT_HIGH, INT_LOW, RET_REQ, POP_REQ, CALL_REQ, // [R12]
                      PUSH_REQ, JUMP_REQ, LOW_WR, STEP_REQ);
  assign push_req = (op == pcrs_pkg::OP_INT) || (op == pcrs_pkg::OP_CALL) ||
                    (op == pcrs_pkg::OP_PUSH);
  assign reg_ok = !push_req && (op != pcrs_pkg::OP_RET) && (op != pcrs_pkg::OP_POP);
  assign ovf_opt = q.cfg[`PCRS_CFG_OVF_BIT];
  assign in_range = 32'(q.fetch) < MEM_BYTES;

  pcrs_stack_mem #(
    .DEPTH (`PCRS_DEPTH),
    .W     (`PCRS_PC_W)
  ) u_mem (
    .clk     (SYS_CLK),
    .nrst    (NRST),
    .we      (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .be      (wr_be),
    .rd_idx  (q.ptr),
    .rd_data (top_rd)
  );

  always_comb begin
    d = q;
    d.devrst = 1'b0;
    d.tos = top_rd; // [R18]
    d.fetch_ok = in_range; // [R1]
    d.instr = q.fetch_ok ? PMEM_DATA : 16'h0000; // [R1]
    wr_en = 1'b0;
    wr_idx = q.ptr;
    wr_data = q.pc;
    wr_be = 3'h7;
    stk_rst = 1'b0;
    if (HIGH_LATCH_WR) begin
      d.hlat = WR_DATA; // [R7]
    end
    if (UPPER_LATCH_WR) begin
      d.ulat = WR_DATA[4:0]; // [R7]
    end
    if (q.run && LOW_RD) begin
      d.hlat = q.pc[15:8]; // [R9]
      d.ulat = q.pc[20:16]; // [R9]
    end
    // flags only clear on a written zero
    if (PTR_WR && !WR_DATA[`PCRS_FULL_BIT]) begin
      d.full = 1'b0; // [R23]
    end
    if (PTR_WR && !WR_DATA[`PCRS_UNF_BIT]) begin
      d.unf = 1'b0; // [R23]
    end
    case (q.st)
      pcrs_pkg::ST_LOAD: begin
        d.cnt = q.cnt + 2'h1;
        if (q.cnt != 2'h0) begin
          d.cfg[{q.cnt - 2'h1, 4'h0} +: 16] = PMEM_DATA; // [R4] [R5]
        end
        if (q.cnt == `PCRS_CFG_USED) begin
          d.st = pcrs_pkg::ST_RUN;
          d.cnt = 2'h0;
        end
      end
      pcrs_pkg::ST_RUN: begin
        case (op)
          pcrs_pkg::OP_INT: begin
            d.pc = INT_HIGH ? `PCRS_HI_VEC : `PCRS_LO_VEC; // [R3]
          end
          pcrs_pkg::OP_CALL,
          pcrs_pkg::OP_JUMP: begin
            d.pc = {JUMP_ADDR[20:1], 1'b0}; // [R11] [R13]
          end
          pcrs_pkg::OP_RET,
          pcrs_pkg::OP_POP: begin
            if (q.ptr == `PCRS_PTR_EMPTY) begin
              d.unf = 1'b1; // [R22]
              stk_rst = ovf_opt; // [R22]
              if (op == pcrs_pkg::OP_RET) begin
                d.pc = `PCRS_RST_VEC; // [R22]
              end
            end else begin
              if (op == pcrs_pkg::OP_RET) begin
                d.pc = {top_rd[20:1], 1'b0}; // [R16] [R13]
              end
              d.ptr = q.ptr - 5'h01; // [R16]
            end
          end
          pcrs_pkg::OP_LOWWR: begin
            d.pc = {q.ulat, q.hlat, WR_DATA[7:1], 1'b0}; // [R8] [R10]
          end
          pcrs_pkg::OP_INC: begin
            d.pc = q.pc + `PCRS_STEP; // [R10]
          end
          default: begin
            d.pc = q.pc;
          end
        endcase
        if (push_req) begin
          if (q.ptr == `PCRS_PTR_TOP) begin
            d.full = 1'b1; // [R21]
            stk_rst = ovf_opt;
          end else begin
            wr_en = 1'b1; // [R15]
            wr_idx = q.ptr + 5'h01; // [R15]
            d.ptr = q.ptr + 5'h01; // [R15]
            if (q.ptr == `PCRS_PTR_ALMOST) begin
              d.full = 1'b1; // [R20]
              if (ovf_opt) begin
                wr_data = q.pc + `PCRS_STEP; // [R21]
                stk_rst = 1'b1; // [R21]
              end
            end
          end
        end
        if (reg_ok && PTR_WR) begin
          d.ptr = WR_DATA[4:0]; // [R18]
        end
        if (reg_ok && q.ptr != `PCRS_PTR_EMPTY &&
            (TOP_LOW_WR || TOP_HIGH_WR || TOP_UPPER_WR)) begin
          wr_en = 1'b1; // [R18]
          wr_idx = q.ptr;
          wr_data = {WR_DATA[4:0], WR_DATA, WR_DATA};
          wr_be = {TOP_UPPER_WR, TOP_HIGH_WR, TOP_LOW_WR};
        end
      end
      default: begin
        d.st = pcrs_pkg::ST_LOAD;
      end
    endcase
    // device reset: flags survive, pointer clears
    if (SOFT_RST || stk_rst) begin
      d.st = pcrs_pkg::ST_LOAD;
      d.cnt = 2'h0;
      d.pc = `PCRS_RST_VEC; // [R2]
      d.ptr = `PCRS_PTR_EMPTY; // [R17]
      d.hlat = 8'h00;
      d.ulat = 5'h00;
      d.devrst = stk_rst;
    end
    d.run = (d.st == pcrs_pkg::ST_RUN);
    d.fetch = d.run ? d.pc : CFG_BASE + {18'h0, d.cnt, 1'b0}; // [R6]
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      q <= RST_Q;
    end else begin
      q <= d;
    end
  end

  assign PROG_ADDR = q.fetch;
  assign INSTR = q.instr;
  assign COUNTER_LOW_BYTE = q.pc[7:0];
  assign COUNTER_HIGH_LATCH = q.hlat;
  assign COUNTER_UPPER_LATCH = q.ulat;
  assign RETURN_POINTER = {q.full, q.unf, 1'b0, q.ptr};
  assign TOP_ENTRY = q.tos;
  assign CONFIG_WORDS = q.cfg;
  assign RUNNING = q.run;
  assign DEV_RESET = q.devrst;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);

  // the release edge still holds the reset state, so it starts no load count
  sequence load_start_s;
    NRST && q.st == pcrs_pkg::ST_LOAD && q.cnt == 2'h0 && !SOFT_RST;
  endsequence
  sequence load_hold_s;
    (!SOFT_RST)[*3];
  endsequence
  property cfg_load_p;
    load_start_s ##1 load_hold_s |=> q.run;
  endproperty
  cfg_load_a: assert property (cfg_load_p) // [R4]
    else $error("config load did not finish in four cycles");
  cfg_order_a: assert property ( // [R5]
    q.st == pcrs_pkg::ST_LOAD && q.cnt == 2'h1 && !SOFT_RST
      |=> q.cfg[15:0] == $past(PMEM_DATA))
    else $error("first config word not in low half");
  cfg_addr_a: assert property ( // [R6]
    q.st == pcrs_pkg::ST_LOAD |-> q.fetch == CFG_BASE + {18'h0, q.cnt, 1'b0})
    else $error("config fetch address wrong");
  fetch_zero_a: assert property ( // [R1]
    32'(q.fetch) >= MEM_BYTES |-> ##2 q.instr == 16'h0000)
    else $error("fetch beyond memory not zero");
  reset_vector_a: assert property ( // [R2]
    SOFT_RST |=> q.pc == `PCRS_RST_VEC && q.ptr == `PCRS_PTR_EMPTY && !q.run)
    else $error("reset did not load vector");
  int_vector_a: assert property ( // [R3]
    q.run && !SOFT_RST && op == pcrs_pkg::OP_INT && q.ptr < `PCRS_PTR_ALMOST
      |=> q.pc == ($past(INT_HIGH) ? `PCRS_HI_VEC : `PCRS_LO_VEC))
    else $error("wrong interrupt vector");
  low_write_a: assert property ( // [R8]
    q.run && !SOFT_RST && op == pcrs_pkg::OP_LOWWR
      |=> q.pc == {$past(q.ulat), $past(q.hlat), $past(WR_DATA[7:1]), 1'b0})
    else $error("low byte write did not take latches");
  low_read_a: assert property ( // [R9]
    q.run && !SOFT_RST && !stk_rst && LOW_RD
      |=> q.hlat == $past(q.pc[15:8]) && q.ulat == $past(q.pc[20:16]))
    else $error("low byte read did not fill latches");
  step_two_a: assert property ( // [R10]
    q.run && !SOFT_RST && op == pcrs_pkg::OP_INC |=> q.pc == $past(q.pc) + `PCRS_STEP)
    else $error("sequential step not two");
  latch_keep_a: assert property ( // [R13]
    q.run && !SOFT_RST && (op == pcrs_pkg::OP_CALL || op == pcrs_pkg::OP_RET) &&
    !HIGH_LATCH_WR && !UPPER_LATCH_WR && !LOW_RD && q.ptr != `PCRS_PTR_EMPTY &&
    q.ptr < `PCRS_PTR_ALMOST |=> $stable(q.hlat) && $stable(q.ulat))
    else $error("call or return moved latches");
  push_ptr_a: assert property ( // [R15]
    q.run && !SOFT_RST && push_req && q.ptr < `PCRS_PTR_ALMOST
      |=> q.ptr == $past(q.ptr) + 5'h01 ##1 q.tos == $past(q.pc, 2))
    else $error("push did not store counter");
  pop_ptr_a: assert property ( // [R16]
    q.run && !SOFT_RST && op == pcrs_pkg::OP_RET && q.ptr != `PCRS_PTR_EMPTY
      |=> q.ptr == $past(q.ptr) - 5'h01 && q.pc == {$past(top_rd[20:1]), 1'b0})
    else $error("pop did not restore counter");
  full_set_a: assert property ( // [R20]
    q.run && push_req && q.ptr == `PCRS_PTR_ALMOST |=> q.full)
    else $error("full flag missed on last push");
  full_hold_a: assert property ( // [R21]
    q.run && !SOFT_RST && push_req && q.ptr == `PCRS_PTR_TOP && !ovf_opt
      |=> q.ptr == `PCRS_PTR_TOP && q.full)
    else $error("pointer left top on extra push");
  underflow_a: assert property ( // [R22]
    q.run && !SOFT_RST && op == pcrs_pkg::OP_RET && q.ptr == `PCRS_PTR_EMPTY
      |=> q.unf && q.ptr == `PCRS_PTR_EMPTY && q.pc == `PCRS_RST_VEC)
    else $error("underflow not handled");
  flag_sticky_a: assert property ( // [R23]
    q.full && !(PTR_WR && !WR_DATA[`PCRS_FULL_BIT]) |=> q.full)
    else $error("full flag dropped without clear");

endmodule

/* File: testbench/pcrs_pmem_model.sv */
`timescale 1ns/1ps

module pcrs_pmem_model #(
  parameter int unsigned MEM_BYTES = 32'h00010000,
  parameter logic [15:0] CFG1      = 16'h1b2c,
  parameter logic [15:0] CFG2      = 16'h3d4e,
  parameter logic [15:0] CFG3      = 16'hffff
) (
  input  wire logic        clk,
  input  wire logic [15:0] cfg0,
  input  wire logic [20:0] addr,
  output logic      [15:0] data
);
  logic [31:0] off;

  assign off = 32'(addr) - (MEM_BYTES - 32'h8);

  // one-cycle fetch latency
  always_ff @(posedge clk) begin
    if (32'(addr) >= MEM_BYTES) begin
      // nonzero on purpose: the core must blank it
      data <= addr[15:0] ^ 16'h9e37;
    end else if (32'(addr) >= MEM_BYTES - 32'h8) begin
      case (off[2:1])
        2'h0: data <= cfg0;
        2'h1: data <= CFG1;
        2'h2: data <= CFG2;
        default: data <= CFG3;
      endcase
    end else begin
      data <= {addr[8:1], 8'h5a};
    end
  end
endmodule

/* File: testbench/test_pcrs_top.sv */
`timescale 1ns/1ps

module test_pcrs_top;
  localparam int unsigned MEM = 32'h00010000;
  localparam logic [15:0] W0  = 16'h00a0;
  localparam logic [15:0] W1  = 16'h1b2c;
  localparam logic [15:0] W2  = 16'h3d4e;
  localparam int S_STEP = 0, S_JUMP = 1, S_CALL = 2, S_INTH = 3, S_INTL = 4, S_RET = 5;
  localparam int S_PUSH = 6, S_POP = 7, S_LOWWR = 8, S_LOWRD = 9, S_HLWR = 10, S_ULWR = 11;
  localparam int S_PTRWR = 12, S_TLWR = 13, S_THWR = 14, S_TUWR = 15, S_SRST = 16;

  logic        sys_clk;
  logic        nrst;
  logic [16:0] stb;
  logic [20:0] jump_addr;
  logic [7:0]  wr_data;
  logic [15:0] pmem_data;
  logic [20:0] prog_addr;
  logic [15:0] instr;
  logic [7:0]  low_byte;
  logic [7:0]  hi_lat;
  logic [4:0]  up_lat;
  logic [7:0]  ret_ptr;
  logic [20:0] top_entry;
  logic [47:0] config_words;
  logic        running;
  logic        dev_reset;
  logic [15:0] cfg0;
  int          errors;
  int          cmp_count;
  int          i;
  logic [20:0] ret_pc [3] = '{21'h000008, 21'h000100, 21'h00abc0};

  pcrs_top #(.MEM_BYTES(MEM)) i_pcrs_top (
    .SYS_CLK(sys_clk), .NRST(nrst), .SOFT_RST(stb[S_SRST]), .STEP_REQ(stb[S_STEP]),
    .JUMP_REQ(stb[S_JUMP]), .CALL_REQ(stb[S_CALL]), .JUMP_ADDR(jump_addr),
    .INT_HIGH(stb[S_INTH]), .INT_LOW(stb[S_INTL]), .RET_REQ(stb[S_RET]),
    .PUSH_REQ(stb[S_PUSH]), .POP_REQ(stb[S_POP]), .WR_DATA(wr_data),
    .LOW_WR(stb[S_LOWWR]), .LOW_RD(stb[S_LOWRD]), .HIGH_LATCH_WR(stb[S_HLWR]),
    .UPPER_LATCH_WR(stb[S_ULWR]), .PTR_WR(stb[S_PTRWR]), .TOP_LOW_WR(stb[S_TLWR]),
    .TOP_HIGH_WR(stb[S_THWR]), .TOP_UPPER_WR(stb[S_TUWR]), .PMEM_DATA(pmem_data),
    .PROG_ADDR(prog_addr), .INSTR(instr), .COUNTER_LOW_BYTE(low_byte),
    .COUNTER_HIGH_LATCH(hi_lat), .COUNTER_UPPER_LATCH(up_lat), .RETURN_POINTER(ret_ptr),
    .TOP_ENTRY(top_entry), .CONFIG_WORDS(config_words), .RUNNING(running),
    .DEV_RESET(dev_reset)
  );

  pcrs_pmem_model #(.MEM_BYTES(MEM), .CFG1(W1), .CFG2(W2)) i_pcrs_pmem_model (
    .clk(sys_clk), .cfg0(cfg0), .addr(prog_addr), .data(pmem_data)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic test_done;
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic pulse(input int b, input logic [20:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    stb[b]    <= 1'b1;
    jump_addr <= a;
    wr_data   <= d;
    @(posedge sys_clk);
    stb[b] <= 1'b0;
    #1;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_run;
    int k;
    for (k = 0; k < 20 && running !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    if (running !== 1'b1) begin
      errors++;
      test_done();
    end
  endtask

  task automatic chk_lat(input logic [7:0] h, input logic [4:0] u);
    check(48'(hi_lat), 48'(h));
    check(48'(up_lat), 48'(u));
  endtask

  initial begin
    nrst = 1'b0;
    stb = '0;
    jump_addr = '0;
    wr_data = '0;
    cfg0 = W0;
    errors = 0;
    cmp_count = 0;
    repeat (6) @(posedge sys_clk);
    #1;
    check(48'(prog_addr), 48'h00fff8);
    @(posedge sys_clk);
    nrst <= 1'b1;
    wait_run();
    check(config_words, {W2, W1, W0});
    check(48'(prog_addr), 48'h0);
    check(48'(ret_ptr), 48'h0);
    pulse(S_STEP, 21'h0, 8'h0);
    check(48'(prog_addr), 48'h2);
    pulse(S_HLWR, 21'h0, 8'h12);
    pulse(S_ULWR, 21'h0, 8'h01);
    chk_lat(8'h12, 5'h01);
    pulse(S_LOWWR, 21'h0, 8'h35);
    check(48'(prog_addr), 48'h011234);
    check(48'(low_byte), 48'h34);
    pulse(S_JUMP, 21'h00abc1, 8'h0);
    check(48'(prog_addr), 48'h00abc0);
    pulse(S_CALL, 21'h000100, 8'h0);
    check(48'(prog_addr), 48'h000100);
    check(48'(ret_ptr), 48'h01);
    idle(1);
    check(48'(top_entry), 48'h00abc0);
    pulse(S_INTH, 21'h0, 8'h0);
    check(48'(prog_addr), 48'h000008);
    pulse(S_INTL, 21'h0, 8'h0);
    check(48'(prog_addr), 48'h000018);
    check(48'(ret_ptr), 48'h03);
    for (i = 0; i < 3; i++) begin
      pulse(S_RET, 21'h0, 8'h0);
      check(48'(prog_addr), 48'(ret_pc[i]));
      check(48'(ret_ptr), 48'(2 - i));
    end
    chk_lat(8'h12, 5'h01);
    pulse(S_LOWRD, 21'h0, 8'h0);
    chk_lat(8'hab, 5'h00);
    pulse(S_RET, 21'h0, 8'h0);
    check(48'(prog_addr), 48'h0);
    check(48'(ret_ptr), 48'h40);
    check(48'(dev_reset), 48'h0);
    pulse(S_POP, 21'h0, 8'h0);
    check(48'(ret_ptr), 48'h40);
    pulse(S_PTRWR, 21'h0, 8'h00);
    check(48'(ret_ptr), 48'h00);
    pulse(S_JUMP, 21'h000a10, 8'h0);
    for (i = 1; i <= 31; i++) begin
      pulse(S_PUSH, 21'h0, 8'h0);
      check(48'(ret_ptr), (i == 31) ? 48'h9f : 48'(i));
    end
    check(48'(dev_reset), 48'h0);
    pulse(S_JUMP, 21'h000c20, 8'h0);
    pulse(S_PUSH, 21'h0, 8'h0);
    check(48'(ret_ptr), 48'h9f);
    idle(1);
    check(48'(top_entry), 48'h000a10);
    pulse(S_PTRWR, 21'h0, 8'h05);
    check(48'(ret_ptr), 48'h05);
    pulse(S_TLWR, 21'h0, 8'h77);
    pulse(S_THWR, 21'h0, 8'h66);
    pulse(S_TUWR, 21'h0, 8'h03);
    idle(1);
    check(48'(top_entry), 48'h036677);
    pulse(S_RET, 21'h0, 8'h0);
    check(48'(prog_addr), 48'h036676);
    check(48'(ret_ptr), 48'h04);
    pulse(S_PTRWR, 21'h0, 8'h00);
    pulse(S_POP, 21'h0, 8'h0);
    pulse(S_SRST, 21'h0, 8'h0);
    check(48'(running), 48'h0);
    check(48'(ret_ptr), 48'h40);
    wait_run();
    check(48'(prog_addr), 48'h0);
    pulse(S_JUMP, 21'h010000, 8'h0);
    idle(3);
    check(48'(instr), 48'h0);
    pulse(S_JUMP, 21'h000a10, 8'h0);
    idle(3);
    check(48'(instr), 48'h085a);
    // overflow option on: reload config, then overflow and underflow resets
    cfg0 <= W0 | 16'h0001;
    pulse(S_SRST, 21'h0, 8'h0);
    wait_run();
    check(config_words, {W2, W1, W0 | 16'h0001});
    pulse(S_JUMP, 21'h000a10, 8'h0);
    pulse(S_PTRWR, 21'h0, 8'h1e);
    check(48'(ret_ptr), 48'h1e);
    pulse(S_PUSH, 21'h0, 8'h0);
    check(48'(dev_reset), 48'h1);
    check(48'(ret_ptr), 48'h80);
    check(48'(running), 48'h0);
    wait_run();
    check(48'(dev_reset), 48'h0);
    pulse(S_PTRWR, 21'h0, 8'h9f);
    check(48'(ret_ptr), 48'h9f);
    idle(1);
    check(48'(top_entry), 48'h000a12);
    pulse(S_PTRWR, 21'h0, 8'h00);
    pulse(S_RET, 21'h0, 8'h0);
    check(48'(dev_reset), 48'h1);
    check(48'(ret_ptr), 48'h40);
    test_done();
  end
endmodule
